/* File: design/hcl_regs.svh */
// Contract
// [RULE1] Configuration block comes first in the stream and is parsed first.
// [RULE2] Block is 23 bytes from memory, 19 bytes from host download.
// [RULE3] Host download skips four memory-only bytes; first byte is CD-ROM mask.
// [RULE4] Memory is present only when its first bytes are 55h then BBh.
// [RULE5] Memory bytes three and four give resource length, high byte first.
// [RULE6] Byte five bits 2..0 give CD-ROM select range; codes 000,001,011,111.
// [RULE7] Byte five defaults to zero, upper five bits reserved.
// [RULE8] Byte six is modem port length mask, default 03h.
// [RULE9] Byte seven holds polarity, key disable and volume bits, default 80h.
// [RULE10] Byte eight holds global option bits, default 00h.
// [RULE11] Source writes byte nine as 0Bh.
// [RULE12] Source writes reserved bytes ten to sixteen and eighteen at defaults.
// [RULE13] Byte seventeen 00 gives 4-byte decode, 08h 8-byte and pin becomes addr bit 2.
// [RULE14] Bytes 19 to 21 map interrupt pins A to F, low nibble first.
// [RULE15] Bytes 22 and 23 map DMA pins A to C, low nibble first.
// [RULE16] Source writes upper nibble of DMA C byte as zero.
// [RULE17] Mappings resolve interrupt and DMA selections made by software.
// [RULE18] Memory is read at power-up for configuration and following data; the loader reads only the configuration block.
// [RULE19] Bad validation keeps defaults and waits for a host download.
`ifndef HCL_REGS_SVH
`define HCL_REGS_SVH
`define HCL_LEN_MEM      8'h17
`define HCL_LEN_HOST     8'h13
`define HCL_SKIP_HOST    8'h04
`define HCL_VALID1       8'h55
`define HCL_VALID2       8'hBB
`define HCL_DEF_LEN      16'h00DD
`define HCL_DEF_ACD      8'h00
`define HCL_DEF_MODEM    8'h03
`define HCL_DEF_MISC     8'h80
`define HCL_DEF_GLOBAL   8'h00
`define HCL_DEF_PERIPH   8'h00
`define HCL_PERIPH_WIDE  8'h08
`define HCL_DEF_IRQ      24'hFCB975
`define HCL_DEF_DMA      12'h310
`define HCL_IDX_LENHI    8'h02
`define HCL_IDX_LENLO    8'h03
`define HCL_IDX_ACD      8'h04
`define HCL_IDX_MODEM    8'h05
`define HCL_IDX_MISC     8'h06
`define HCL_IDX_GLOBAL   8'h07
`define HCL_IDX_PERIPH   8'h10
`define HCL_IDX_IRQ_AB   8'h12
`define HCL_IDX_IRQ_CD   8'h13
`define HCL_IDX_IRQ_EF   8'h14
`define HCL_IDX_DMA_AB   8'h15
`define HCL_IDX_DMA_C    8'h16
`endif

/* File: design/hcl_pkg.sv */
package hcl_pkg;
	typedef logic [7:0] hcl_byte_t;
	typedef enum logic [1:0] {
		HCL_SRC_NONE,
		HCL_SRC_MEM,
		HCL_SRC_HOST
	} hcl_src_e;
	typedef enum {
		HCL_IDLE,
		HCL_MEM,
		HCL_HOST,
		HCL_DONE
	} hcl_state_e;
	typedef struct packed {
		logic [7:0]  altCdromLenMask;
		logic [7:0]  modemPortLenMask;
		logic [7:0]  miscCfg;
		logic [7:0]  globalCfg;
		logic [7:0]  periphLen;
		logic [23:0] irqMap;
		logic [11:0] dmaMap;
	} hcl_cfg_s;
endpackage

/* File: design/hcl_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module hcl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;
	logic [AW:0]      next_wrPtr;
	logic [AW:0]      next_rdPtr;
	logic             doWr;
	logic             doRd;

	// Full when pointers differ only in the wrap bit
	always_comb
	begin
		inReady    = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
		outValid   = wrPtr != rdPtr;
		outData    = mem[rdPtr[AW-1:0]];
		doWr       = inValid && inReady;
		doRd       = outValid && outReady;
		next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
		next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
	end

	// Storage has no reset; only pointers define contents
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
		end
		if (doWr)
			mem[wrPtr[AW-1:0]] <= inData;
	end
endmodule
`default_nettype wire

/* File: design/hcl_loader.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hcl_regs.svh"
module hcl_loader #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic        [7:0] memData,
	input  wire logic              memValid,
	output logic                   memReady,
	input  wire logic        [7:0] hostData,
	input  wire logic              hostValid,
	output logic                   hostReady,
	input  wire logic              hostStart,
	input  wire logic        [2:0] irqPinSel,
	input  wire logic        [1:0] dmaPinSel,
	output var hcl_pkg::hcl_cfg_s  cfg,
	output logic            [15:0] resourceLen,
	output logic                   memPresent,
	output logic                   cfgDone,
	output logic                   acdReserved,
	output logic                   periphAddrBit2,
	output logic             [3:0] sysIrq,
	output logic             [3:0] sysDma
);
	hcl_pkg::hcl_state_e state;
	hcl_pkg::hcl_state_e next_state;
	hcl_pkg::hcl_src_e   src;
	hcl_pkg::hcl_src_e   next_src;
	hcl_pkg::hcl_cfg_s   next_cfg;
	logic [7:0]  idx;
	logic [7:0]  next_idx;
	logic [15:0] next_resourceLen;
	logic        next_memPresent;
	logic        next_cfgDone;
	logic [7:0]  fData;
	logic        fValid;
	logic        fReady;
	logic [7:0]  inMux;
	logic        inValidMux;
	logic        inReadyF;
	logic        fifoClr;
	logic        take;
	logic [7:0]  pos;
	logic [3:0]  next_sysIrq;
	logic [3:0]  next_sysDma;

	// Both sources share one FIFO; only the active one sees ready
	always_comb
	begin
		inMux      = (state == hcl_pkg::HCL_HOST) ? hostData : memData;
		inValidMux = (state == hcl_pkg::HCL_HOST) ? hostValid :
			(state == hcl_pkg::HCL_MEM) ? memValid : 1'b0;
		memReady   = (state == hcl_pkg::HCL_MEM) && inReadyF;
		hostReady  = (state == hcl_pkg::HCL_HOST) && inReadyF;
		// Bytes pushed past a rejected or finished stream must not leak into the next download
		fifoClr    = rst || (state == hcl_pkg::HCL_DONE); // see [RULE19]
	end

	hcl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.rst      (fifoClr),
		.inData   (inMux),
		.inValid  (inValidMux),
		.inReady  (inReadyF),
		.outData  (fData),
		.outValid (fValid),
		.outReady (fReady)
	);

	// Parser drains one byte per cycle while loading
	always_comb
	begin
		fReady = (state == hcl_pkg::HCL_MEM) || (state == hcl_pkg::HCL_HOST);
		take   = fReady && fValid;
		// Host bytes start four positions in, so one index table serves both
		pos    = (src == hcl_pkg::HCL_SRC_HOST) ? idx + `HCL_SKIP_HOST : idx; // see [RULE3]
	end

	// Byte parser: configuration block is the first thing in the stream
	always_comb
	begin
		next_state       = state;
		next_src         = src;
		next_idx         = idx;
		next_cfg         = cfg;
		next_resourceLen = resourceLen;
		next_memPresent  = memPresent;
		next_cfgDone     = cfgDone;
		unique case (state)
			hcl_pkg::HCL_IDLE:
			begin
				// Power-up read of the memory begins right after reset
				next_state = hcl_pkg::HCL_MEM; // see [RULE18] see [RULE1]
				next_src   = hcl_pkg::HCL_SRC_MEM;
				next_idx   = '0;
			end
			hcl_pkg::HCL_MEM, hcl_pkg::HCL_HOST:
			begin
				if (take)
				begin
					next_idx = idx + 8'h01;
					if (state == hcl_pkg::HCL_MEM && idx == 8'h00 && fData != `HCL_VALID1)
						next_state = hcl_pkg::HCL_DONE; // see [RULE19]
					else if (state == hcl_pkg::HCL_MEM && idx == 8'h01 && fData != `HCL_VALID2)
						next_state = hcl_pkg::HCL_DONE; // see [RULE19]
					else if (state == hcl_pkg::HCL_MEM && idx == 8'h01)
						next_memPresent = 1'b1; // see [RULE4]
					unique case (pos)
						`HCL_IDX_LENHI:  next_resourceLen[15:8] = fData; // see [RULE5]
						`HCL_IDX_LENLO:  next_resourceLen[7:0]  = fData; // see [RULE5]
						`HCL_IDX_ACD:    next_cfg.altCdromLenMask = {5'h00, fData[2:0]}; // see [RULE6] see [RULE7]
						`HCL_IDX_MODEM:  next_cfg.modemPortLenMask = fData; // see [RULE8]
						`HCL_IDX_MISC:   next_cfg.miscCfg = fData; // see [RULE9]
						`HCL_IDX_GLOBAL: next_cfg.globalCfg = fData; // see [RULE10]
						`HCL_IDX_PERIPH: next_cfg.periphLen = fData; // see [RULE13]
						`HCL_IDX_IRQ_AB: next_cfg.irqMap[7:0] = fData; // see [RULE14]
						`HCL_IDX_IRQ_CD: next_cfg.irqMap[15:8] = fData; // see [RULE14]
						`HCL_IDX_IRQ_EF: next_cfg.irqMap[23:16] = fData; // see [RULE14]
						`HCL_IDX_DMA_AB: next_cfg.dmaMap[7:0] = fData; // see [RULE15]
						`HCL_IDX_DMA_C:  next_cfg.dmaMap[11:8] = fData[3:0]; // see [RULE15] see [RULE16]
						default:         next_idx = next_idx; // Reserved bytes are skipped
					endcase
					// Length depends on source: 23 from memory, 19 from host
					if ((state == hcl_pkg::HCL_MEM && idx == `HCL_LEN_MEM - 8'h01) ||
						(state == hcl_pkg::HCL_HOST && idx == `HCL_LEN_HOST - 8'h01))
					begin
						next_state   = hcl_pkg::HCL_DONE; // see [RULE2]
						next_cfgDone = 1'b1;
					end
				end
			end
			hcl_pkg::HCL_DONE:
			begin
				// A host download may replace the table at any later time
				if (hostStart)
				begin
					next_state   = hcl_pkg::HCL_HOST; // see [RULE19]
					next_src     = hcl_pkg::HCL_SRC_HOST;
					next_idx     = '0;
					next_cfgDone = 1'b0;
				end
			end
		endcase
	end

	// Pin-to-number lookup for software resource selections
	always_comb
	begin
		next_sysIrq = cfg.irqMap[{irqPinSel, 2'b00} +: 4]; // see [RULE17]
		next_sysDma = (dmaPinSel == 2'b11) ? 4'h0 : cfg.dmaMap[{dmaPinSel, 2'b00} +: 4]; // see [RULE17]
	end

	// Register stage; defaults stand until a byte overwrites them
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state       <= hcl_pkg::HCL_IDLE;
			src         <= hcl_pkg::HCL_SRC_NONE;
			idx         <= '0;
			resourceLen <= `HCL_DEF_LEN;
			memPresent  <= 1'b0;
			cfgDone     <= 1'b0;
			cfg.altCdromLenMask  <= `HCL_DEF_ACD; // see [RULE7]
			cfg.modemPortLenMask <= `HCL_DEF_MODEM; // see [RULE8]
			cfg.miscCfg          <= `HCL_DEF_MISC; // see [RULE9]
			cfg.globalCfg        <= `HCL_DEF_GLOBAL; // see [RULE10]
			cfg.periphLen        <= `HCL_DEF_PERIPH;
			cfg.irqMap           <= `HCL_DEF_IRQ;
			cfg.dmaMap           <= `HCL_DEF_DMA;
			acdReserved    <= 1'b0;
			periphAddrBit2 <= 1'b0;
			sysIrq         <= '0;
			sysDma         <= '0;
		end
		else
		begin
			state       <= next_state;
			src         <= next_src;
			idx         <= next_idx;
			resourceLen <= next_resourceLen;
			memPresent  <= next_memPresent;
			cfgDone     <= next_cfgDone;
			cfg         <= next_cfg;
			// Flag codes outside the four legal run lengths
			acdReserved    <= !(next_cfg.altCdromLenMask[2:0] inside {3'b000, 3'b001, 3'b011, 3'b111}); // see [RULE6]
			periphAddrBit2 <= next_cfg.periphLen == `HCL_PERIPH_WIDE; // see [RULE13]
			sysIrq         <= next_sysIrq;
			sysDma         <= next_sysDma;
		end
	end

	// Checks
	a_bad_valid_one: assert property (@(posedge mclk) disable iff (rst) // see [RULE4]
		state == hcl_pkg::HCL_MEM && take && idx == 8'h00 && fData != `HCL_VALID1
		|=> state == hcl_pkg::HCL_DONE && !memPresent && !cfgDone)
		else $error("first validation mismatch not rejected");
	a_valid_pair_ok: assert property (@(posedge mclk) disable iff (rst) // see [RULE4]
		state == hcl_pkg::HCL_MEM && take && idx == 8'h01 && fData == `HCL_VALID2 |=> memPresent)
		else $error("memory not marked present");
	a_len_hi_byte: assert property (@(posedge mclk) disable iff (rst) // see [RULE5]
		state == hcl_pkg::HCL_MEM && take && idx == `HCL_IDX_LENHI |=> resourceLen[15:8] == $past(fData))
		else $error("length high byte wrong");
	a_host_first_acd: assert property (@(posedge mclk) disable iff (rst) // see [RULE3]
		state == hcl_pkg::HCL_HOST && take && idx == 8'h00 |=> cfg.altCdromLenMask == {5'h00, $past(fData[2:0])})
		else $error("host first byte not CD-ROM mask");
	a_mem_done_len: assert property (@(posedge mclk) disable iff (rst) // see [RULE2]
		state == hcl_pkg::HCL_MEM && take && idx == 8'h16 |=> cfgDone)
		else $error("memory block not 23 bytes");
	a_host_done_len: assert property (@(posedge mclk) disable iff (rst) // see [RULE2]
		state == hcl_pkg::HCL_HOST && take && idx == 8'h12 |=> cfgDone && state == hcl_pkg::HCL_DONE)
		else $error("host block not 19 bytes");
	a_acd_upper_zero: assert property (@(posedge mclk) disable iff (rst) // see [RULE7]
		cfg.altCdromLenMask[7:3] == 5'h00)
		else $error("reserved CD-ROM bits set");
	a_periph_pin: assert property (@(posedge mclk) disable iff (rst) // see [RULE13]
		cfg.periphLen == `HCL_PERIPH_WIDE && $stable(cfg.periphLen) |-> periphAddrBit2)
		else $error("shared pin not switched");
	a_irq_lookup: assert property (@(posedge mclk) disable iff (rst) // see [RULE17]
		irqPinSel == 3'h0 |=> sysIrq == $past(cfg.irqMap[3:0]))
		else $error("irq map lookup wrong");
	a_dma_nibble: assert property (@(posedge mclk) disable iff (rst) // see [RULE15]
		state == hcl_pkg::HCL_HOST && take && idx == 8'h11 |=> cfg.dmaMap[3:0] == $past(fData[3:0]))
		else $error("dma A nibble wrong");
	c_mem_load: cover property (@(posedge mclk) disable iff (rst)
		state == hcl_pkg::HCL_MEM ##1 cfgDone && memPresent);
	c_mem_reject: cover property (@(posedge mclk) disable iff (rst)
		state == hcl_pkg::HCL_MEM ##1 state == hcl_pkg::HCL_DONE && !memPresent);
	c_host_load: cover property (@(posedge mclk) disable iff (rst)
		state == hcl_pkg::HCL_HOST ##1 cfgDone);
	c_fifo_full: cover property (@(posedge mclk) disable iff (rst) !inReadyF);
endmodule
`default_nettype wire

/* File: tb/hcl_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module hcl_src_model (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               go,
	input  wire logic               stall,
	input  wire logic         [4:0] first,
	input  wire hcl_pkg::hcl_byte_t image [0:22],
	output logic              [7:0] data,
	output logic                    valid,
	input  wire logic               ready
);
	logic [4:0] idx;
	logic       on;
	logic       gap;
	logic [7:0] last;

	// Image order, one byte per taken handshake, stream ends at byte 23
	always @(posedge mclk)
	begin
		if (rst || go)
		begin
			idx  <= first;
			on   <= go;
			gap  <= 1'b0;
			last <= 8'h00;
		end
		else
		begin
			if (valid && ready)
			begin
				last <= data;
				idx  <= idx + 5'h01;
				on   <= (idx != 5'h16);
			end
			// Gaps only start while nothing is offered or as the offered byte is taken, so a byte is never withdrawn
			if (!valid || ready)
				gap <= stall && ($urandom_range(2) == 0);
		end
	end

	// Idle lines show the inverse of the last byte so a stale copy cannot pass
	assign valid = on && !gap;
	assign data  = valid ? image[idx] : ~last;
endmodule
`default_nettype wire

/* File: tb/hw_config_byte_loader_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module hw_config_byte_loader_tb_top;
	logic               mclk, rst, memGo, hostGo, memStall, hostStall, hostStart;
	logic         [7:0] memData, hostData;
	logic               memValid, memReady, hostValid, hostReady;
	logic         [2:0] irqPinSel;
	logic         [1:0] dmaPinSel;
	hcl_pkg::hcl_cfg_s  cfg;
	logic        [15:0] resourceLen;
	logic               memPresent, cfgDone, acdReserved, periphAddrBit2;
	logic         [3:0] sysIrq, sysDma;
	hcl_pkg::hcl_byte_t memImg [0:22];
	hcl_pkg::hcl_byte_t hostImg [0:22];
	hcl_pkg::hcl_byte_t dflt [0:22];
	int                 miscompares, checksDone;

	hcl_loader #(.FIFO_DEPTH(8)) u_hcl_loader (.mclk(mclk), .rst(rst), .memData(memData), .memValid(memValid),
		.memReady(memReady), .hostData(hostData), .hostValid(hostValid), .hostReady(hostReady),
		.hostStart(hostStart), .irqPinSel(irqPinSel), .dmaPinSel(dmaPinSel), .cfg(cfg), .resourceLen(resourceLen),
		.memPresent(memPresent), .cfgDone(cfgDone), .acdReserved(acdReserved), .periphAddrBit2(periphAddrBit2),
		.sysIrq(sysIrq), .sysDma(sysDma));
	hcl_src_model u_hcl_src_model (.mclk(mclk), .rst(rst), .go(memGo), .stall(memStall), .first(5'h00),
		.image(memImg), .data(memData), .valid(memValid), .ready(memReady));
	hcl_src_model u_hcl_src_model_host (.mclk(mclk), .rst(rst), .go(hostGo), .stall(hostStall), .first(5'h04),
		.image(hostImg), .data(hostData), .valid(hostValid), .ready(hostReady));

	// Free-running device clock, 100 ns period
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Legal image: fixed bytes at their required values, random fields elsewhere
	task automatic fillImg(output hcl_pkg::hcl_byte_t b [0:22], input logic [2:0] acd);
		b = dflt;
		b[2] = 8'($urandom);
		b[3] = 8'($urandom);
		b[4] = {5'h00, acd};
		for (int i = 5; i < 8; i++)
			b[i] = 8'($urandom);
		b[16] = $urandom_range(1) ? 8'h08 : 8'h00;
		for (int i = 18; i < 22; i++)
			b[i] = 8'($urandom);
		b[22] = {4'h0, 4'($urandom)};
	endtask

	task automatic checkCfg(input hcl_pkg::hcl_byte_t b [0:22]);
		logic [23:0] im;
		logic [15:0] dm;
		im = {b[20], b[19], b[18]};
		dm = {4'h0, b[22][3:0], b[21]};
		check(cfg.altCdromLenMask, b[4]);
		check(cfg.modemPortLenMask, b[5]);
		check(cfg.miscCfg, b[6]);
		check(cfg.globalCfg, b[7]);
		check(cfg.periphLen, b[16]);
		check(periphAddrBit2, b[16] == 8'h08);
		check(cfg.irqMap, im);
		check(cfg.dmaMap, dm[11:0]);
		check(acdReserved, !(b[4][2:0] inside {3'b000, 3'b001, 3'b011, 3'b111}));
		// Every pin select, including the unused fourth DMA code; selects change on the rising edge
		for (int p = 0; p < 6; p++)
		begin
			@(posedge mclk);
			irqPinSel <= 3'(p);
			dmaPinSel <= 2'(p);
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			check(sysIrq, 4'(im >> (4 * p)));
			check(sysDma, 4'(dm >> (4 * (p % 4))));
		end
	endtask

	task automatic waitDone(input logic hostSide);
		int n;
		n = 0;
		while (((hostSide ? u_hcl_src_model_host.on : u_hcl_src_model.on) || cfgDone !== 1'b1) && n < 300)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 300)
		begin
			miscompares++;
			wrapUp();
		end
	endtask

	task automatic hostLoad(input logic [2:0] acd);
		fillImg(hostImg, acd);
		@(posedge mclk);
		hostStart <= 1'b1;
		hostGo    <= 1'b1;
		hostStall <= acd[0];
		@(posedge mclk);
		hostStart <= 1'b0;
		hostGo    <= 1'b0;
		// Let the start land so the previous load's done flag is not taken for this one
		@(negedge mclk);
		waitDone(1'b1);
		checkCfg(hostImg);
	endtask

	task automatic memLoad();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst   <= 1'b0;
		@(posedge mclk);
		memGo <= 1'b1;
		@(posedge mclk);
		memGo <= 1'b0;
	endtask

	// Main sequence: defaults, memory load, host loads, bad memory, buffer
	initial
	begin
		void'($urandom(32'hf929));
		{rst, memGo, hostGo, memStall, hostStall, hostStart} = 6'h20;
		{irqPinSel, dmaPinSel} = '0;
		miscompares = 0;
		checksDone  = 0;
		dflt = '{8'h55, 8'hBB, 8'h00, 8'hDD, 8'h00, 8'h03, 8'h80, 8'h00, 8'h0B, 8'h20, 8'h04, 8'h08, 8'h10, 8'h80,
			8'h00, 8'h00, 8'h00, 8'h48, 8'h75, 8'hB9, 8'hFC, 8'h10, 8'h03};
		memImg  = dflt;
		hostImg = dflt;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		checkCfg(dflt);
		check(resourceLen, 16'h00DD);
		fillImg(memImg, 3'b011);
		memStall <= 1'b1;
		memLoad();
		waitDone(1'b0);
		checkCfg(memImg);
		check(resourceLen, {memImg[2], memImg[3]});
		check(memPresent, 1'b1);
		check(memReady, 1'b0);
		for (int c = 0; c < 8; c++)
			hostLoad(3'(c));
		// Bad second validation byte: no done flag ever comes, so wait a fixed, gap-free span
		memImg[1] = 8'hBA;
		memStall  <= 1'b0;
		memLoad();
		repeat (10) @(negedge mclk);
		checkCfg(dflt);
		check({memPresent, memReady}, 2'b00);
		// Buffer must hold nothing left over from the rejected memory stream
		hostLoad(3'b111);
		// Back-to-back gap-free host loads through the buffer, then bytes offered with no start
		hostLoad(3'b110);
		hostLoad(3'b010);
		@(posedge mclk);
		hostGo <= 1'b1;
		@(posedge mclk);
		hostGo <= 1'b0;
		repeat (4) @(negedge mclk);
		check(hostReady, 1'b0);
		check(cfgDone, 1'b1);
		check(resourceLen, 16'h00DD);
		checkCfg(hostImg);
		wrapUp();
	end
endmodule
`default_nettype wire
